// >>> rtl/eqr_defines.svh
// Offsets-free constants: clock rate, timing counts, heat default and current width
`ifndef EQR_DEFINES_SVH
`define EQR_DEFINES_SVH
`define EQR_CLK_HZ 25000000
`define EQR_RD_MIN_MS 10
`define EQR_SAMPLE_MS 5
`define EQR_SAMPLE_CYC ((`EQR_CLK_HZ / 1000) * `EQR_SAMPLE_MS)
`define EQR_HOLD_MS 500
`define EQR_HOLD_CYC ((`EQR_CLK_HZ / 1000) * `EQR_HOLD_MS)
`define EQR_HEAT_S_DEF 20
`define EQR_CUR_W 24
`endif

// >>> rtl/eqr_pkg.sv
// Types shared by the quench and rampdown controller
package eqr_pkg;
  typedef enum logic [7:0] {
    EQR_IDLE = 8'h01,
    EQR_MATCH = 8'h02,
    EQR_HOLD = 8'h04,
    EQR_HEAT = 8'h08,
    EQR_ZEROING = 8'h10,
    EQR_DONE = 8'h20,
    EQR_QUENCH = 8'h40
  } eqr_state_e;

  typedef struct packed {
    logic rampPause;
    logic escape;
    logic confirm;
    logic quenchClearKey;
    logic quenchClearRemote;
  } eqr_keys_s;

  typedef struct packed {
    logic quenchLatched;
    logic rampdownActive;
    logic rampdownDone;
    logic operatorLocked;
  } eqr_status_s;
endpackage

// >>> rtl/eqr_sync2.sv
// Two-flop synchroniser for contact inputs
`timescale 1ns/1ps
module eqr_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_ff;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_ff <= asyncIn;
      syncOut <= stage1_ff;
    end
  end
endmodule

// >>> rtl/eqr_ctl.sv
// Quench protection and external rampdown sequencer
`timescale 1ns/1ps
`include "eqr_defines.svh"
module eqr_ctl #(
  parameter int CUR_W = `EQR_CUR_W,
  parameter int SAMPLE_CYC = `EQR_SAMPLE_CYC,
  parameter int HOLD_CYC = `EQR_HOLD_CYC,
  parameter int SEC_CYC = `EQR_CLK_HZ,
  parameter int MAX_ERR = 256
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic extQuenchIn,
  input wire logic extRampdownIn,
  input wire logic rampdownEnable,
  input wire logic intDetectEnable,
  input wire logic intQuenchEvent,
  input wire logic persistentMode,
  input wire logic switchUncommandedNormal,
  input wire logic [6:0] heatTimeSec,
  input wire eqr_pkg::eqr_keys_s keys,
  input wire logic signed [CUR_W-1:0] presentCurrent,
  input wire logic signed [CUR_W-1:0] magnetCurrent,
  input wire logic signed [CUR_W-1:0] operatorSetpoint,
  output logic signed [CUR_W-1:0] currentCmd,
  output logic zeroVoltCmd,
  output logic quenchOut,
  output logic bypass_switch_heater,
  output logic setpoint_reached_lamp,
  output logic persistentLampOff,
  output logic pausedOut,
  output logic zeroCurrentOut,
  output eqr_pkg::eqr_status_s status,
  output eqr_pkg::eqr_keys_s keysGated
);
  // Elaboration guard on parameter ranges
  initial begin
    if (CUR_W < 8 || SAMPLE_CYC < 1 || HOLD_CYC < 1 || SEC_CYC < 1
        || MAX_ERR < 1) begin
      $error("eqr_ctl: parameter out of range");
    end
  end

  localparam logic signed [CUR_W-1:0] ZERO_CUR = '0;
  localparam logic signed [CUR_W-1:0] ERR_LIM = CUR_W'(MAX_ERR);

  eqr_pkg::eqr_state_e state_ff;
  eqr_pkg::eqr_state_e nxt_state;
  logic extQuenchSync;
  logic rampSync;
  logic rampSample_ff;
  logic [31:0] sampleCnt_ff;
  logic [31:0] timer_ff;
  logic [6:0] heatSec_ff;
  logic quenchLatch_ff;
  logic intQuench;
  logic clearReq;
  logic quenchSet;
  logic sampleTick;
  logic signed [CUR_W-1:0] holdCur_ff;
  logic signed [CUR_W-1:0] err;
  logic signed [CUR_W-1:0] nxt_cmd;
  logic paused_ff;
  logic heatDone;
  logic holdDone;

  // Contact inputs; open contact reads as low, so no false trip
  // Low reset value matches an open contact: no false edge after reset
  eqr_sync2 #(.RESET_VAL(1'b0)) u_syncQuench (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .asyncIn(extQuenchIn),
    .syncOut(extQuenchSync)
  );
  eqr_sync2 #(.RESET_VAL(1'b0)) u_syncRamp (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .asyncIn(extRampdownIn),
    .syncOut(rampSync)
  );

  // Sample period half the 10 ms minimum, so a valid closure is seen
  // Worst-case start lag is one sample period plus the two sync flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleCnt_ff <= '0;
    end else if (sampleTick) begin
      sampleCnt_ff <= '0;
    end else begin
      sampleCnt_ff <= sampleCnt_ff + 32'h1;
    end
  end
  assign sampleTick = (sampleCnt_ff == 32'(SAMPLE_CYC - 1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rampSample_ff <= 1'b0;
    end else if (sampleTick) begin
      rampSample_ff <= rampSync;
    end
  end

  // Internal trip only when enabled; external path has no enable
  // Live command is compared, so a step still in flight can also trip
  assign intQuench = intDetectEnable
    && (intQuenchEvent
        || (switchUncommandedNormal
            && magnetCurrent != currentCmd));
  assign quenchSet = extQuenchSync || intQuench;
  // Clear refused while external contact still closed
  assign clearReq = (keys.quenchClearKey || keys.quenchClearRemote)
    && !extQuenchSync;

  // Quench latch; a new trip wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      quenchLatch_ff <= 1'b0;
    end else if (quenchSet) begin
      quenchLatch_ff <= 1'b1;
    end else if (clearReq) begin
      quenchLatch_ff <= 1'b0;
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      eqr_pkg::EQR_IDLE: begin
        if (rampdownEnable && rampSample_ff) begin
          if (persistentMode) begin
            nxt_state = eqr_pkg::EQR_MATCH;
          end else begin
            nxt_state = eqr_pkg::EQR_ZEROING;
          end
        end
      end
      eqr_pkg::EQR_MATCH: begin
        if (currentCmd == magnetCurrent) begin
          nxt_state = eqr_pkg::EQR_HOLD;
        end
      end
      eqr_pkg::EQR_HOLD: begin
        if (holdDone) begin
          nxt_state = eqr_pkg::EQR_HEAT;
        end
      end
      eqr_pkg::EQR_HEAT: begin
        if (heatDone) begin
          nxt_state = eqr_pkg::EQR_ZEROING;
        end
      end
      eqr_pkg::EQR_ZEROING: begin
        if (currentCmd == ZERO_CUR) begin
          nxt_state = eqr_pkg::EQR_DONE;
        end
      end
      eqr_pkg::EQR_DONE: begin
        if (!rampSync && keys.confirm) begin
          nxt_state = eqr_pkg::EQR_IDLE;
        end
      end
      eqr_pkg::EQR_QUENCH: begin
        if (!quenchLatch_ff) begin
          nxt_state = eqr_pkg::EQR_IDLE;
        end
      end
      default: nxt_state = eqr_pkg::EQR_IDLE;
    endcase
    // A quench preempts any sequence step
    // Checked last, so no case branch above can override it
    if (quenchLatch_ff) begin
      nxt_state = eqr_pkg::EQR_QUENCH;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= eqr_pkg::EQR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hold and heat timers; heat counts whole seconds
  // Any state change restarts them, so an interrupted hold starts over
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_ff <= '0;
      heatSec_ff <= '0;
    end else if (state_ff != nxt_state) begin
      timer_ff <= '0;
      heatSec_ff <= '0;
    end else if (state_ff == eqr_pkg::EQR_HOLD) begin
      timer_ff <= timer_ff + 32'h1;
    end else if (state_ff == eqr_pkg::EQR_HEAT) begin
      if (timer_ff == 32'(SEC_CYC - 1)) begin
        timer_ff <= '0;
        heatSec_ff <= heatSec_ff + 7'h01;
      end else begin
        timer_ff <= timer_ff + 32'h1;
      end
    end
  end
  assign holdDone = (timer_ff == 32'(HOLD_CYC - 1));
  assign heatDone = (heatSec_ff >= heatTimeSec)
    && (heatTimeSec != 7'h00 || timer_ff != '0);

  // Error between wanted and present current, clamped in idle when undetected
  always_comb begin
    nxt_cmd = currentCmd;
    err = '0;
    unique case (state_ff)
      eqr_pkg::EQR_MATCH: nxt_cmd = magnetCurrent;
      eqr_pkg::EQR_ZEROING: nxt_cmd = ZERO_CUR;
      eqr_pkg::EQR_QUENCH: nxt_cmd = presentCurrent;
      eqr_pkg::EQR_HOLD,
      eqr_pkg::EQR_HEAT,
      eqr_pkg::EQR_DONE: nxt_cmd = currentCmd;
      eqr_pkg::EQR_IDLE: begin
        if (paused_ff) begin
          nxt_cmd = holdCur_ff;
        end else if (switchUncommandedNormal && !intDetectEnable) begin
          nxt_cmd = magnetCurrent;
        end else if (zeroCurrentOut) begin
          // Zero-current mode holds until the operator resumes
          nxt_cmd = ZERO_CUR;
        end else begin
          nxt_cmd = operatorSetpoint;
        end
        if (!intDetectEnable) begin
          err = nxt_cmd - presentCurrent;
          // Limit so magnet terminals see no excess voltage
          if (err > ERR_LIM) begin
            nxt_cmd = presentCurrent + ERR_LIM;
          end else if (err < -ERR_LIM) begin
            nxt_cmd = presentCurrent - ERR_LIM;
          end
        end
      end
      default: nxt_cmd = currentCmd;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      currentCmd <= '0;
    end else begin
      currentCmd <= nxt_cmd;
    end
  end

  // Paused after clear, holding current seen at the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      paused_ff <= 1'b0;
      holdCur_ff <= '0;
    end else if (quenchLatch_ff && clearReq && !quenchSet) begin
      paused_ff <= 1'b1;
      holdCur_ff <= presentCurrent;
    end else if (state_ff == eqr_pkg::EQR_DONE) begin
      // Rampdown ends in zero-current mode, not in a stale pause
      paused_ff <= 1'b0;
    end else if (state_ff == eqr_pkg::EQR_IDLE && keys.rampPause) begin
      paused_ff <= 1'b0;
    end
  end

  // Registered indicator and drive outputs
  // Trip feeds the drive directly, saving a cycle of exposure
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      zeroVoltCmd <= 1'b0;
      quenchOut <= 1'b0;
      bypass_switch_heater <= 1'b0;
      setpoint_reached_lamp <= 1'b0;
      persistentLampOff <= 1'b0;
      zeroCurrentOut <= 1'b0;
    end else begin
      zeroVoltCmd <= quenchSet || quenchLatch_ff;
      quenchOut <= quenchSet || quenchLatch_ff;
      // Heater stays on after heating so the supply keeps the magnet;
      // a new persistent sequence starts with the switch cold
      if (nxt_state == eqr_pkg::EQR_HEAT) begin
        bypass_switch_heater <= 1'b1;
      end else if (nxt_state == eqr_pkg::EQR_MATCH) begin
        bypass_switch_heater <= 1'b0;
      end
      setpoint_reached_lamp <= (nxt_state == eqr_pkg::EQR_HOLD)
        || (nxt_state == eqr_pkg::EQR_HEAT);
      if (state_ff == eqr_pkg::EQR_HEAT && heatDone) begin
        persistentLampOff <= 1'b1;
      end else if (nxt_state == eqr_pkg::EQR_MATCH) begin
        persistentLampOff <= 1'b0;
      end
      if (state_ff == eqr_pkg::EQR_DONE && nxt_state == eqr_pkg::EQR_IDLE)
      begin
        zeroCurrentOut <= 1'b1;
      end else if (state_ff != eqr_pkg::EQR_IDLE) begin
        zeroCurrentOut <= 1'b0;
      end else if (keys.rampPause) begin
        zeroCurrentOut <= 1'b0;
      end
    end
  end

  assign pausedOut = paused_ff;

  // Operator keys pass only when neither quench nor rampdown owns control
  // Done counts as active, so keys stay blocked until release and confirm
  always_comb begin
    status.quenchLatched = quenchLatch_ff;
    status.rampdownActive = (state_ff != eqr_pkg::EQR_IDLE)
      && (state_ff != eqr_pkg::EQR_QUENCH);
    status.rampdownDone = (state_ff == eqr_pkg::EQR_DONE);
    status.operatorLocked = quenchLatch_ff
      || status.rampdownActive;
    keysGated = status.operatorLocked ? '0 : keys;
  end
endmodule

// >>> sim/eqr_contacts.sv
// Relay contact model for the quench and rampdown inputs
`timescale 1ns/1ps
module eqr_contacts (
  output logic extQuenchIn,
  output logic extRampdownIn,
  input wire logic ref_clk
);
  // Open contacts read low through a pull-down
  initial begin
    extQuenchIn = 1'b0;
    extRampdownIn = 1'b0;
  end
  // Contacts move just after an edge, like a slow relay
  task automatic set_quench(input logic v);
    @(posedge ref_clk) extQuenchIn <= v;
  endtask
  // Caller holds a start closure for two sample periods or more
  task automatic set_rampdown(input logic v);
    @(posedge ref_clk) extRampdownIn <= v;
  endtask
endmodule

// >>> sim/eqr_ctl_checker.sv
// Port assertions for the quench and rampdown controller
`timescale 1ns/1ps
module eqr_ctl_checker #(
  parameter int SAMPLE_CYC = 4,
  parameter int HOLD_CYC = 8,
  parameter int SEC_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic extQuenchIn,
  input wire logic extRampdownIn,
  input wire logic rampdownEnable,
  input wire logic [6:0] heatTimeSec,
  input wire eqr_pkg::eqr_keys_s keys,
  input wire logic zeroVoltCmd,
  input wire logic quenchOut,
  input wire logic bypass_switch_heater,
  input wire logic setpoint_reached_lamp,
  input wire logic persistentLampOff,
  input wire logic pausedOut,
  input wire logic zeroCurrentOut,
  input wire eqr_pkg::eqr_status_s status,
  input wire eqr_pkg::eqr_keys_s keysGated
);
  int lampCnt;
  int shutCnt;
  int heatLen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  assign heatLen = HOLD_CYC + int'(heatTimeSec) * SEC_CYC;
  // Lamp-on and closure lengths; closure count saturates
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lampCnt <= 0;
      shutCnt <= 0;
    end else begin
      lampCnt <= setpoint_reached_lamp ? lampCnt + 1 : 0;
      shutCnt <= !extRampdownIn ? 0 : (shutCnt < 999 ? shutCnt + 1 : 999);
    end
  end
  property p_qzero;
    extQuenchIn [*4] |=> zeroVoltCmd && quenchOut;
  endproperty
  a_qzero: assert property (p_qzero) else $error("quench not zeroed");
  property p_lock;
    status.operatorLocked |-> keysGated == '0;
  endproperty
  a_lock: assert property (p_lock) else $error("keys leak");
  property p_free;
    !status.operatorLocked |-> keysGated == keys;
  endproperty
  a_free: assert property (p_free) else $error("keys lost");
  property p_keep;
    extQuenchIn [*3] ##0 status.quenchLatched |=> status.quenchLatched;
  endproperty
  a_keep: assert property (p_keep) else $error("latch dropped");
  property p_pause;
    $fell(status.quenchLatched) |-> ##[0:1] pausedOut;
  endproperty
  a_pause: assert property (p_pause) else $error("no pause");
  property p_heat;
    $rose(bypass_switch_heater) && status.rampdownActive |->
      setpoint_reached_lamp && lampCnt >= HOLD_CYC && lampCnt <= HOLD_CYC + 1;
  endproperty
  a_heat: assert property (p_heat) else $error("hold length");
  property p_heatlen;
    $fell(setpoint_reached_lamp) && status.rampdownActive |->
      lampCnt >= heatLen - 1 && lampCnt <= heatLen + 1;
  endproperty
  a_heatlen: assert property (p_heatlen) else $error("heat length");
  property p_lampoff;
    $fell(setpoint_reached_lamp) |-> ##[0:1] persistentLampOff;
  endproperty
  a_lampoff: assert property (p_lampoff) else $error("lamp stays");
  property p_start;
    shutCnt == SAMPLE_CYC + 5 && rampdownEnable |->
      status.rampdownActive || status.rampdownDone || status.quenchLatched;
  endproperty
  a_start: assert property (p_start) else $error("no rampdown");
  property p_ignore;
    status.rampdownDone && keys.confirm && extRampdownIn &&
      $past(extRampdownIn) && $past(extRampdownIn, 2) |=> status.rampdownDone;
  endproperty
  a_ignore: assert property (p_ignore) else $error("confirm taken");
  property p_resume;
    status.rampdownDone && keys.confirm && !extRampdownIn &&
      !$past(extRampdownIn) && !$past(extRampdownIn, 2) |->
      ##[1:2] zeroCurrentOut;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  c_quench: cover property ($rose(status.quenchLatched));
  c_heat: cover property ($rose(bypass_switch_heater));
  c_done: cover property ($rose(zeroCurrentOut));
endmodule
bind eqr_ctl eqr_ctl_checker #(.SAMPLE_CYC(SAMPLE_CYC), .HOLD_CYC(HOLD_CYC),
  .SEC_CYC(SEC_CYC)) eqr_ctl_checker_i (.ref_clk, .arst_n, .extQuenchIn,
  .extRampdownIn, .rampdownEnable, .heatTimeSec, .keys, .zeroVoltCmd,
  .quenchOut, .bypass_switch_heater, .setpoint_reached_lamp,
  .persistentLampOff, .pausedOut, .zeroCurrentOut, .status, .keysGated);

// >>> sim/tb_eqr_ctl.sv
// Testbench for the quench and rampdown controller
`timescale 1ns/1ps
module tb_eqr_ctl;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic extQuenchIn, extRampdownIn, zeroVoltCmd, quenchOut, pausedOut;
  logic rampdownEnable, intDetectEnable, intQuenchEvent;
  logic persistentMode, switchUncommandedNormal;
  logic bypass_switch_heater, setpoint_reached_lamp, persistentLampOff;
  logic zeroCurrentOut, lampSeen = 1'b0;
  logic [6:0] heatTimeSec;
  logic signed [23:0] presentCurrent = 24'sh0, magnetCurrent;
  logic signed [23:0] operatorSetpoint, currentCmd;
  eqr_pkg::eqr_keys_s keys, keysGated;
  eqr_pkg::eqr_status_s status;
  int fail_count = 0, tests_run = 0, cycles = 0, n;
  eqr_contacts eqr_contacts_i (.extQuenchIn, .extRampdownIn, .ref_clk);
  eqr_ctl #(.SAMPLE_CYC(4), .HOLD_CYC(8), .SEC_CYC(10)) eqr_ctl_i (.ref_clk,
    .arst_n, .extQuenchIn, .extRampdownIn, .rampdownEnable, .intDetectEnable,
    .intQuenchEvent, .persistentMode, .switchUncommandedNormal, .heatTimeSec,
    .keys, .presentCurrent, .magnetCurrent, .operatorSetpoint, .currentCmd,
    .zeroVoltCmd, .quenchOut, .bypass_switch_heater, .setpoint_reached_lamp,
    .persistentLampOff, .pausedOut, .zeroCurrentOut, .status, .keysGated);
  always #20 ref_clk = ~ref_clk;
  // Ideal supply follows the command; lamp history for skip checks
  always @(posedge ref_clk) begin
    presentCurrent <= currentCmd;
    if (setpoint_reached_lamp === 1'b1) lampSeen <= 1'b1;
  end
  // Hang guard, well above the roughly two hundred cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: check %0d got %b", $time, tests_run, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Keys are one-cycle pulses
  task automatic press(input eqr_pkg::eqr_keys_s k);
    @(posedge ref_clk) keys <= k;
    @(posedge ref_clk) keys <= '0;
    @(negedge ref_clk);
  endtask
  task automatic final_report;
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rampdownEnable <= 1'b1;
    intDetectEnable <= 1'b0;
    intQuenchEvent <= 1'b0;
    persistentMode <= 1'b0;
    switchUncommandedNormal <= 1'b0;
    heatTimeSec <= 7'h02;
    magnetCurrent <= 24'sh64;
    operatorSetpoint <= 24'sh0;
    keys <= '0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(6);
    chk(quenchOut, 1'b0);
    // Large setpoint step is limited to the error bound per cycle
    @(posedge ref_clk) operatorSetpoint <= 24'sh1000;
    cyc(1);
    chk(currentCmd === 24'sh100, 1'b1);
    @(posedge ref_clk) operatorSetpoint <= 24'sh0;
    cyc(3);
    // Key clear then remote clear, detection off then on
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) intDetectEnable <= i[0];
      eqr_contacts_i.set_quench(1'b1);
      cyc(4);
      chk(zeroVoltCmd, 1'b1);
      chk(quenchOut, 1'b1);
      chk(status.operatorLocked, 1'b1);
      press(5'h02);
      cyc(2);
      chk(status.quenchLatched, 1'b1);
      eqr_contacts_i.set_quench(1'b0);
      cyc(4);
      press(i ? 5'h01 : 5'h02);
      cyc(1);
      chk(status.quenchLatched, 1'b0);
      chk(pausedOut, 1'b1);
    end
    // Uncommanded switch and internal trip, detection off then on
    press(5'h10);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) intDetectEnable <= i[0];
      switchUncommandedNormal <= 1'b1;
      intQuenchEvent <= !i[0];
      magnetCurrent <= 24'sh46 + 24'(i);
      cyc(6);
      chk(quenchOut, i[0]);
      if (i == 0) chk(currentCmd === 24'sh46, 1'b1);
      @(posedge ref_clk) switchUncommandedNormal <= 1'b0;
      intQuenchEvent <= 1'b0;
      press(5'h01);
      cyc(1);
    end
    // Closure ignored while the rampdown feature is off
    @(posedge ref_clk) rampdownEnable <= 1'b0;
    eqr_contacts_i.set_rampdown(1'b1);
    cyc(12);
    chk(status.rampdownActive, 1'b0);
    eqr_contacts_i.set_rampdown(1'b0);
    cyc(8);
    @(posedge ref_clk) rampdownEnable <= 1'b1;
    operatorSetpoint <= 24'sh20;
    // Rampdown in persistent mode, then shortest closure without it
    for (int p = 1; p >= 0; p--) begin
      @(posedge ref_clk) persistentMode <= p[0];
      magnetCurrent <= 24'sh64;
      lampSeen <= 1'b0;
      eqr_contacts_i.set_rampdown(1'b1);
      if (p == 1) begin
        for (n = 0; n < 99 && setpoint_reached_lamp !== 1'b1; n++) cyc(0);
        chk(currentCmd === 24'sh64, 1'b1);
        chk(bypass_switch_heater, 1'b0);
        press(5'h10);
        chk(status.operatorLocked, 1'b1);
        for (n = 0; n < 99 && setpoint_reached_lamp !== 1'b0; n++) cyc(0);
        cyc(1);
        chk(persistentLampOff, 1'b1);
        chk(bypass_switch_heater, 1'b1);
      end else begin
        cyc(7);
        eqr_contacts_i.set_rampdown(1'b0);
      end
      for (n = 0; n < 99 && status.rampdownDone !== 1'b1; n++) cyc(0);
      chk(currentCmd === 24'sh0, 1'b1);
      chk(lampSeen, p[0]);
      // Short closure already released: close again for the refusal check
      if (p == 0) begin
        eqr_contacts_i.set_rampdown(1'b1);
        cyc(2);
      end
      press(5'h04);
      cyc(1);
      chk(zeroCurrentOut, 1'b0);
      eqr_contacts_i.set_rampdown(1'b0);
      cyc(4);
      press(5'h04);
      cyc(1);
      chk(zeroCurrentOut, 1'b1);
      chk(status.operatorLocked, 1'b0);
      chk(currentCmd === 24'sh0, 1'b1);
    end
    final_report();
  end
endmodule
